// ===== jcs_config_seq.sv
// Scan-port configuration loader of a programmable device: instruction
// register, configuration and bypass data registers, startup and shutdown
// sequencing on the scan clock, and configuration memory on the core clock.
// Assumes tck_i is the external host's scan clock, free of core_clk_i.
`timescale 1ns/1ns
`default_nettype none

module jcs_config_seq #(
    parameter int                     MEM_DEPTH   = 64,
    parameter logic [jcs_pkg::WORD_W-1:0] SYNC_WORD = 32'h5a5a_a5a5,
    parameter logic [jcs_pkg::WORD_W-1:0] CRC_RESET_CMD = 32'h0000_0001,
    parameter logic [jcs_pkg::WORD_W-1:0] GLOBAL_HIGH_ASSERT_CMD = 32'h0000_0002
) (
    input  wire logic                       core_clk_i,
    input  wire logic                       arst_n_i,
    input  wire logic                       tck_i,
    input  wire logic                       tms_i,
    input  wire logic                       tdi_i,
    output logic                            tdo_o,
    output logic                            tdo_oe_o,
    input  wire logic                       prog_n_i,
    input  wire logic [$clog2(MEM_DEPTH)-1:0] rd_addr_i,
    output logic      [jcs_pkg::WORD_W-1:0] rd_data_o,
    output logic                            rd_valid_o,
    output logic      [jcs_pkg::WORD_W-1:0] cfg_crc_o,
    output logic                            global_output_hold_n_o,
    output logic                            device_operational_o
);
    import jcs_pkg::*;

    localparam int AW = $clog2(MEM_DEPTH);

    // **********************************************************************
    // Scan clock domain
    // **********************************************************************
    jcs_tap_state_e    tap_state;
    logic [IR_W-1:0]   ir_sh_r, ir_sh_nxt, instr_r, instr_nxt;
    logic [WORD_W-1:0] cfg_sh_r, cfg_sh_nxt, word_hold_r, word_hold_nxt;
    logic [BITC_W-1:0] bit_cnt_r, bit_cnt_nxt;
    logic [SEQ_W-1:0]  seq_cnt_r, seq_cnt_nxt;
    logic              bypass_r, bypass_nxt, word_tgl_r, word_tgl_nxt;
    logic              startup_done_r, startup_done_nxt;
    logic              shutdown_done_r, shutdown_done_nxt;
    logic              tlr_r, tlr_nxt;
    logic              seq_run;
    logic              tdo_nxt, tdo_oe_nxt;

    // Scan port controller
    jcs_tap_fsm u_tap (
        .tck_i    (tck_i),
        .arst_n_i (arst_n_i),
        .tms_i    (tms_i),
        .state_o  (tap_state)
    );

    assign seq_run = (tap_state == TAP_RTI) && (instr_r == INSTR_STARTUP || instr_r == INSTR_SHUTDOWN);

    // Shift, capture, update and sequence counting
    always_comb begin
        ir_sh_nxt         = ir_sh_r;
        instr_nxt         = instr_r;
        cfg_sh_nxt        = cfg_sh_r;
        word_hold_nxt     = word_hold_r;
        word_tgl_nxt      = word_tgl_r;
        bit_cnt_nxt       = bit_cnt_r;
        bypass_nxt        = bypass_r;
        seq_cnt_nxt       = seq_cnt_r;
        startup_done_nxt  = startup_done_r;
        shutdown_done_nxt = shutdown_done_r;
        tlr_nxt           = tms_i && (tap_state == TAP_TLR || tap_state == TAP_SEL_IR);  // Set on the entering edge
        unique case (tap_state)
            TAP_TLR: begin
                instr_nxt = INSTR_BYPASS;
            end
            TAP_CAP_IR: begin
                ir_sh_nxt                  = IR_CAPTURE_BASE;
                ir_sh_nxt[IR_DONE_BIT]     = startup_done_r;
                ir_sh_nxt[IR_INIT_BIT]     = 1'b1;
                ir_sh_nxt[IR_ISC_DONE_BIT] = startup_done_r;
            end
            TAP_SH_IR: begin
                ir_sh_nxt = {tdi_i, ir_sh_r[IR_W-1:1]};
            end
            TAP_UPD_IR: begin
                instr_nxt = ir_sh_r;
                if (ir_sh_r == INSTR_STARTUP || ir_sh_r == INSTR_SHUTDOWN) begin
                    seq_cnt_nxt = '0;
                end
            end
            TAP_CAP_DR: begin
                bypass_nxt  = 1'b0;
                bit_cnt_nxt = '0;
            end
            TAP_SH_DR: begin
                if (instr_r == INSTR_CFG_LOAD) begin
                    cfg_sh_nxt  = {cfg_sh_r[WORD_W-2:0], tdi_i};
                    bit_cnt_nxt = bit_cnt_r + 5'h01;
                    if (bit_cnt_r == BIT_LAST) begin
                        word_hold_nxt = {cfg_sh_r[WORD_W-2:0], tdi_i};
                        word_tgl_nxt  = ~word_tgl_r;
                    end
                end else begin
                    bypass_nxt = tdi_i;
                end
            end
            default: begin
            end
        endcase
        // Startup or shutdown stepped on idle clocks
        if (seq_run && seq_cnt_r != SEQ_CYCLES) begin
            seq_cnt_nxt = seq_cnt_r + 4'h1;
            if (seq_cnt_r == SEQ_CYCLES - 4'h1) begin
                startup_done_nxt  = (instr_r == INSTR_STARTUP);
                shutdown_done_nxt = (instr_r == INSTR_SHUTDOWN);
            end
        end
    end

    // Scan domain registers
    always_ff @(posedge tck_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ir_sh_r         <= IR_CAPTURE_BASE;
            instr_r         <= INSTR_BYPASS;
            cfg_sh_r        <= '0;
            word_hold_r     <= '0;
            word_tgl_r      <= 1'b0;
            bit_cnt_r       <= '0;
            bypass_r        <= 1'b0;
            seq_cnt_r       <= SEQ_CYCLES;
            startup_done_r  <= 1'b0;
            shutdown_done_r <= 1'b0;
            tlr_r           <= 1'b1;
        end else begin
            ir_sh_r         <= ir_sh_nxt;
            instr_r         <= instr_nxt;
            cfg_sh_r        <= cfg_sh_nxt;
            word_hold_r     <= word_hold_nxt;
            word_tgl_r      <= word_tgl_nxt;
            bit_cnt_r       <= bit_cnt_nxt;
            bypass_r        <= bypass_nxt;
            seq_cnt_r       <= seq_cnt_nxt;
            startup_done_r  <= startup_done_nxt;
            shutdown_done_r <= shutdown_done_nxt;
            tlr_r           <= tlr_nxt;
        end
    end

    // Serial output chosen by state and instruction
    always_comb begin
        tdo_oe_nxt = (tap_state == TAP_SH_IR) || (tap_state == TAP_SH_DR);
        if (tap_state == TAP_SH_IR) begin
            tdo_nxt = ir_sh_r[0];
        end else if (instr_r == INSTR_CFG_LOAD) begin
            tdo_nxt = cfg_sh_r[WORD_W-1];
        end else begin
            tdo_nxt = bypass_r;
        end
    end

    // Serial output launched on the falling edge
    always_ff @(negedge tck_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tdo_o    <= 1'b0;
            tdo_oe_o <= 1'b0;
        end else begin
            tdo_o    <= tdo_nxt;
            tdo_oe_o <= tdo_oe_nxt;
        end
    end

    // **********************************************************************
    // Crossing into the core clock domain
    // **********************************************************************
    logic [XS_W-1:0] xs_q;
    logic            prog_n_q;

    jcs_sync #(.WIDTH(XS_W)) u_xs (
        .clk_i    (core_clk_i),
        .arst_n_i (arst_n_i),
        .d_i      ({shutdown_done_r, tlr_r, startup_done_r, word_tgl_r}),
        .q_o      (xs_q)
    );

    jcs_sync #(.WIDTH(1)) u_prog (
        .clk_i    (core_clk_i),
        .arst_n_i (arst_n_i),
        .d_i      (prog_n_i),
        .q_o      (prog_n_q)
    );

    // **********************************************************************
    // Core clock domain
    // **********************************************************************
    logic [WORD_W-1:0]    mem_r [MEM_DEPTH];
    logic [MEM_DEPTH-1:0] valid_r, valid_nxt;
    logic [AW-1:0]        addr_r, addr_nxt;
    logic [XS_W-1:0]      xs_prev_r;
    logic [WORD_W-1:0]    crc_nxt;
    logic                 synced_r, synced_nxt, armed_r, armed_nxt;
    logic                 hold_n_nxt, oper_nxt;
    logic                 word_stb, su_rise, sd_rise, prog_low, mem_we;

    assign word_stb = xs_q[XS_WORD_TGL] ^ xs_prev_r[XS_WORD_TGL];
    assign su_rise  = xs_q[XS_STARTUP] & ~xs_prev_r[XS_STARTUP];
    assign sd_rise  = xs_q[XS_SHUTDOWN] & ~xs_prev_r[XS_SHUTDOWN];
    assign prog_low = ~prog_n_q;
    assign mem_we   = word_stb && synced_r && !prog_low
                      && word_hold_r != CRC_RESET_CMD && word_hold_r != GLOBAL_HIGH_ASSERT_CMD;

    // Packet decode, memory control and device status
    always_comb begin
        valid_nxt  = valid_r;
        addr_nxt   = addr_r;
        synced_nxt = synced_r;
        armed_nxt  = armed_r;
        hold_n_nxt = global_output_hold_n_o;
        oper_nxt   = device_operational_o;
        crc_nxt    = cfg_crc_o;
        if (word_stb && !synced_r && word_hold_r == SYNC_WORD) begin
            synced_nxt = 1'b1;
            addr_nxt   = '0;
        end else if (word_stb && synced_r) begin
            crc_nxt = {cfg_crc_o[WORD_W-2:0], cfg_crc_o[WORD_W-1]} ^ word_hold_r;
            if (word_hold_r == CRC_RESET_CMD) begin
                crc_nxt = '0;
            end else if (word_hold_r == GLOBAL_HIGH_ASSERT_CMD) begin
                hold_n_nxt = 1'b0;
            end
        end
        if (mem_we) begin
            valid_nxt = valid_r | (MEM_DEPTH'(1) << addr_r);
            addr_nxt  = addr_r + AW'(1);
        end
        if (su_rise) begin
            armed_nxt  = 1'b1;
            synced_nxt = 1'b0;
            hold_n_nxt = 1'b1;
        end
        if (armed_r && xs_q[XS_TLR]) begin
            oper_nxt  = 1'b1;
            armed_nxt = 1'b0;
        end
        if (sd_rise) begin
            oper_nxt   = 1'b0;
            hold_n_nxt = 1'b0;
            armed_nxt  = 1'b0;
            synced_nxt = 1'b0;
        end
        if (prog_low) begin
            valid_nxt  = '0;
            addr_nxt   = '0;
            synced_nxt = 1'b0;
            armed_nxt  = 1'b0;
            oper_nxt   = 1'b0;
            hold_n_nxt = 1'b0;
        end
    end

    // Core domain registers
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            valid_r                <= '0;
            addr_r                 <= '0;
            xs_prev_r              <= '0;
            synced_r               <= 1'b0;
            armed_r                <= 1'b0;
            global_output_hold_n_o <= HOLD_N_RESET;
            device_operational_o   <= 1'b0;
            cfg_crc_o              <= '0;
            rd_data_o              <= '0;
            rd_valid_o             <= 1'b0;
        end else begin
            valid_r                <= valid_nxt;
            addr_r                 <= addr_nxt;
            xs_prev_r              <= xs_q;
            synced_r               <= synced_nxt;
            armed_r                <= armed_nxt;
            global_output_hold_n_o <= hold_n_nxt;
            device_operational_o   <= oper_nxt;
            cfg_crc_o              <= crc_nxt;
            rd_data_o              <= mem_r[rd_addr_i];
            rd_valid_o             <= valid_r[rd_addr_i];
        end
    end

    // Configuration memory, never reset
    always_ff @(posedge core_clk_i) begin
        if (mem_we) begin
            mem_r[addr_r] <= word_hold_r;
        end
    end

    // **********************************************************************
    // Checks
    // **********************************************************************
    property p_ir_shift;
        @(posedge tck_i) disable iff (!arst_n_i)
        tap_state == TAP_SH_IR |=> ir_sh_r[IR_W-1] == $past(tdi_i) && ir_sh_r[IR_W-2:0] == $past(ir_sh_r[IR_W-1:1]);
    endproperty
    a_ir_shift: assert property (p_ir_shift) else $error("ir not lsb first");

    property p_cfg_shift;
        @(posedge tck_i) disable iff (!arst_n_i)
        tap_state == TAP_SH_DR && instr_r == INSTR_CFG_LOAD
        |=> cfg_sh_r == {$past(cfg_sh_r[WORD_W-2:0]), $past(tdi_i)};
    endproperty
    a_cfg_shift: assert property (p_cfg_shift) else $error("cfg not msb first");

    property p_instr_update;
        @(posedge tck_i) disable iff (!arst_n_i)
        tap_state == TAP_UPD_IR |=> instr_r == $past(ir_sh_r);
    endproperty
    a_instr_update: assert property (p_instr_update) else $error("instruction not updated");

    property p_startup_begin;
        @(posedge tck_i) disable iff (!arst_n_i)
        tap_state == TAP_UPD_IR && ir_sh_r == INSTR_STARTUP && tms_i == 1'b0
        |=> seq_cnt_r == 4'h0 ##1 seq_cnt_r == 4'h1 || tap_state != TAP_RTI;
    endproperty
    a_startup_begin: assert property (p_startup_begin) else $error("startup not begun");

    property p_startup_done;
        @(posedge tck_i) disable iff (!arst_n_i)
        seq_run && instr_r == INSTR_STARTUP && seq_cnt_r == 4'h0 && !tms_i
        ##1 (!tms_i && tap_state == TAP_RTI) [*8] ##1 (!tms_i && tap_state == TAP_RTI) [*3]
        |=> startup_done_r && !shutdown_done_r;
    endproperty
    a_startup_done: assert property (p_startup_done) else $error("startup not done after 12");

    property p_shutdown_done;
        @(posedge tck_i) disable iff (!arst_n_i)
        seq_run && instr_r == INSTR_SHUTDOWN && seq_cnt_r == SEQ_CYCLES - 4'h1
        |=> shutdown_done_r && !startup_done_r;
    endproperty
    a_shutdown_done: assert property (p_shutdown_done) else $error("shutdown not done");

    property p_operational;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        armed_r && xs_q[XS_TLR] && !prog_low && !sd_rise |=> device_operational_o && !armed_r;
    endproperty
    a_operational: assert property (p_operational) else $error("not operational");

    property p_prog_clear;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        prog_low |=> valid_r == '0 && !device_operational_o && !global_output_hold_n_o;
    endproperty
    a_prog_clear: assert property (p_prog_clear) else $error("program reset did not clear");

    property p_mem_kept;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        !prog_low && !mem_we |=> valid_r == $past(valid_r);
    endproperty
    a_mem_kept: assert property (p_mem_kept) else $error("memory lost without program");

    property p_hold_cmd;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        word_stb && synced_r && word_hold_r == GLOBAL_HIGH_ASSERT_CMD && !su_rise
        |=> !global_output_hold_n_o;
    endproperty
    a_hold_cmd: assert property (p_hold_cmd) else $error("hold not asserted");

endmodule

`default_nettype wire

// ===== jcs_pkg.sv
// Package for the scan-port configuration loader: instruction codes,
// capture layout, sequence counts and the scan controller states.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package jcs_pkg;

    // **********************************************************************
    // Widths
    // **********************************************************************
    localparam int IR_W   = 10;           // Instruction register length
    localparam int WORD_W = 32;           // Configuration word length
    localparam int BITC_W = 5;            // Bit counter inside one word
    localparam int SEQ_W  = 4;            // Startup / shutdown counter width

    // **********************************************************************
    // Instruction codes
    // **********************************************************************
    localparam logic [IR_W-1:0] INSTR_CFG_LOAD = 10'h3c5;
    localparam logic [IR_W-1:0] INSTR_STARTUP  = 10'h3cc;  // startup_instr
    localparam logic [IR_W-1:0] INSTR_SHUTDOWN = 10'h3cd;  // shutdown_instr
    localparam logic [IR_W-1:0] INSTR_BYPASS   = 10'h3ff;

    // **********************************************************************
    // Instruction capture value and its status fields
    // **********************************************************************
    localparam logic [IR_W-1:0] IR_CAPTURE_BASE = 10'h001;
    localparam int              IR_DONE_BIT     = 5;
    localparam int              IR_INIT_BIT     = 4;
    localparam int              IR_ISC_DONE_BIT = 2;

    // **********************************************************************
    // Sequence lengths and reset values
    // **********************************************************************
    localparam logic [SEQ_W-1:0]  SEQ_CYCLES    = 4'hc;   // Clocks of startup or shutdown
    localparam logic [BITC_W-1:0] BIT_LAST      = 5'h1f;  // Last bit of a word
    localparam logic              HOLD_N_RESET  = 1'b0;   // Outputs held after reset

    // **********************************************************************
    // Positions of the levels crossing from the scan clock domain
    // **********************************************************************
    localparam int XS_WORD_TGL = 0;
    localparam int XS_STARTUP  = 1;
    localparam int XS_TLR      = 2;
    localparam int XS_SHUTDOWN = 3;
    localparam int XS_W        = 4;

    // **********************************************************************
    // Scan controller states
    // **********************************************************************
    typedef enum logic [3:0] {
        TAP_TLR, TAP_RTI,
        TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR,
        TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
    } jcs_tap_state_e;

endpackage

`default_nettype wire

// ===== jcs_sync.sv
// Two-flop level synchroniser, one per bit.
// Assumes each input bit is a flop output from another clock domain.
`timescale 1ns/1ns
`default_nettype none

module jcs_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta_r;

    // Two stages; first stage feeds only the second
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_r <= '0;
            q_o    <= '0;
        end else begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end

endmodule

`default_nettype wire

// ===== jcs_tap_fsm.sv
// Sixteen-state scan port controller, stepped by the scan clock.
// Assumes mode select is stable around each rising scan clock edge.
`timescale 1ns/1ns
`default_nettype none

module jcs_tap_fsm (
    input  wire logic                  tck_i,
    input  wire logic                  arst_n_i,
    input  wire logic                  tms_i,
    output jcs_pkg::jcs_tap_state_e    state_o
);
    import jcs_pkg::*;

    jcs_tap_state_e state_nxt;

    // Next state from mode select
    always_comb begin
        state_nxt = state_o;
        unique case (state_o)
            TAP_TLR:    state_nxt = tms_i ? TAP_TLR    : TAP_RTI;
            TAP_RTI:    state_nxt = tms_i ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_DR: state_nxt = tms_i ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: state_nxt = tms_i ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR:  state_nxt = tms_i ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: state_nxt = tms_i ? TAP_UPD_DR : TAP_PAU_DR;
            TAP_PAU_DR: state_nxt = tms_i ? TAP_EX2_DR : TAP_PAU_DR;
            TAP_EX2_DR: state_nxt = tms_i ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: state_nxt = tms_i ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_IR: state_nxt = tms_i ? TAP_TLR    : TAP_CAP_IR;
            TAP_CAP_IR: state_nxt = tms_i ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR:  state_nxt = tms_i ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: state_nxt = tms_i ? TAP_UPD_IR : TAP_PAU_IR;
            TAP_PAU_IR: state_nxt = tms_i ? TAP_EX2_IR : TAP_PAU_IR;
            TAP_EX2_IR: state_nxt = tms_i ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: state_nxt = tms_i ? TAP_SEL_DR : TAP_RTI;
        endcase
    end

    // State register
    always_ff @(posedge tck_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_o <= TAP_TLR;
        end else begin
            state_o <= state_nxt;
        end
    end

endmodule

`default_nettype wire

// ===== jcs_host_model.sv
// Scan host model: drives mode, data and scan clock pins.
// Assumes the device samples its pins on rising scan clock edges.
`timescale 1ns/1ns
`default_nettype none
module jcs_host_model (
    input  wire logic tdo_i,
    input  wire logic tdo_oe_i,
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o
);
    logic       tdo_seen;  // Serial output seen at the last rise
    logic [9:0] ir_cap;    // Status read out during instruction shift
    // Clock stands low between frames
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end
    // One 30 ns scan clock, pins changed while clock low
    task automatic step(input logic m, input logic d);
        tms_o = m;
        tdi_o = d;
        #15 tck_o = 1'b1;
        tdo_seen = tdo_oe_i ? tdo_i : ~tdo_i;  // Released pin reads inverted
        #15 tck_o = 1'b0;
    endtask
    // Repeated mode level, unused data toggles
    task automatic steps(input logic m, input int n);
        repeat (n) step(m, ~tdi_o);
    endtask
    // Reset, load an instruction, end in idle
    task automatic load_ir(input logic [9:0] code);
        steps(1'b1, 5);
        step(1'b0, 1'b0);
        steps(1'b1, 2);
        steps(1'b0, 2);
        for (int i = 0; i < 10; i++) begin
            step(i == 9, code[i]);
            ir_cap[i] = tdo_seen;
        end
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask
    // Words high bit first, last bit leaves shift
    task automatic load_dr(input logic [31:0] w[$]);
        step(1'b1, 1'b0);
        steps(1'b0, 2);
        foreach (w[k]) for (int i = 31; i >= 0; i--) step(k == w.size() - 1 && i == 0, w[k][i]);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask
    // Sequence instruction, twelve idle clocks, back to reset
    task automatic run_seq(input logic [9:0] code);
        load_ir(code);
        steps(1'b0, 12);
        steps(1'b1, 3);
    endtask
endmodule
`default_nettype wire

// ===== jtag_config_sequencer_bench.sv
// Bench for the scan-port configuration loader.
// Assumes the host model drives the scan pins.
`timescale 1ns/1ns
`default_nettype none
module jtag_config_sequencer_bench;
    import jcs_pkg::*;
    localparam logic [31:0] SYNC = 32'h5a5a_a5a5;
    localparam logic [31:0] CRCR = 32'h0000_0001;
    localparam logic [31:0] HOLD = 32'h0000_0002;
    localparam logic [9:0]  CAP_IDLE = IR_CAPTURE_BASE | (10'h001 << IR_INIT_BIT);
    localparam logic [9:0]  CAP_DONE = CAP_IDLE | (10'h001 << IR_DONE_BIT) | (10'h001 << IR_ISC_DONE_BIT);
    logic        core_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        prog_n = 1'b1;
    logic [5:0]  rd_addr = 6'h00;
    wire  logic  tck, tms, tdi, tdo, tdo_oe, rd_valid, hold_n, oper;
    wire  logic [31:0] rd_data, crc;
    int          errors = 0;
    int          comparisons = 0;
    // ****************************************************************
    // Design, host and clock
    // ****************************************************************
    jcs_host_model host (.tdo_i(tdo), .tdo_oe_i(tdo_oe), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));
    jcs_config_seq #(.MEM_DEPTH(64), .SYNC_WORD(SYNC), .CRC_RESET_CMD(CRCR), .GLOBAL_HIGH_ASSERT_CMD(HOLD)) uut (
        .core_clk_i(core_clk), .arst_n_i(arst_n), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo),
        .tdo_oe_o(tdo_oe), .prog_n_i(prog_n), .rd_addr_i(rd_addr), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
        .cfg_crc_o(crc), .global_output_hold_n_o(hold_n), .device_operational_o(oper));
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    // Counted comparison
    task automatic check(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    // Crossing delay, then memory read
    task automatic rd(input logic [5:0] a);
        repeat (8) @(posedge core_clk);
        rd_addr <= a;
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Bitstream load before startup, status read out on the serial pin
    task automatic test_load();
        host.load_ir(INSTR_CFG_LOAD);
        check(host.ir_cap === CAP_IDLE, "capture before startup");
        host.load_dr('{32'h0bad_0bad, SYNC, 32'h1234_5678, 32'h8000_0001});
        rd(6'h00);
        check(rd_data === 32'h1234_5678 && rd_valid === 1'b1, "first word");
        rd(6'h01);
        check(rd_data === 32'h8000_0001 && hold_n === 1'b0, "second word");
        $display("load test done");
    endtask
    // Startup, then return to reset with the scan clock stopped
    task automatic test_startup();
        host.run_seq(INSTR_STARTUP);
        rd(6'h01);
        check(oper === 1'b1 && hold_n === 1'b1, "startup");
        $display("startup test done");
    endtask
    // Hold command and check reset on a running device
    task automatic test_hold();
        host.load_ir(INSTR_CFG_LOAD);
        check(host.ir_cap === CAP_DONE, "capture after startup");
        host.load_dr('{SYNC, HOLD, CRCR});
        rd(6'h00);
        check(hold_n === 1'b0 && crc === 32'h0, "hold and check reset");
        check(rd_data === 32'h1234_5678 && rd_valid === 1'b1, "memory kept");
        $display("hold test done");
    endtask
    // Shutdown to a safe state, then startup again
    task automatic test_shutdown();
        host.run_seq(INSTR_SHUTDOWN);
        rd(6'h00);
        check(oper === 1'b0 && hold_n === 1'b0, "shutdown");
        host.run_seq(INSTR_STARTUP);
        rd(6'h00);
        check(oper === 1'b1 && hold_n === 1'b1, "restart");
        $display("shutdown test done");
    endtask
    // Program reset pulse clears memory valid flags and status
    task automatic test_program();
        @(posedge core_clk);
        prog_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        prog_n <= 1'b1;
        rd(6'h00);
        check(rd_valid === 1'b0 && oper === 1'b0, "program reset");
        $display("program test done");
    endtask
    initial begin
        host.steps(1'b1, 2);
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        test_load();
        test_startup();
        test_hold();
        test_shutdown();
        test_program();
        tally_and_finish();
    end
endmodule
`default_nettype wire
